// ===== rtl/tms_defs.vh
`ifndef TMS_DEFS_VH
`define TMS_DEFS_VH

// Register byte addresses.
`define TMS_ADDR_CFG 8'h00
`define TMS_ADDR_RD1 8'h10
`define TMS_ADDR_AMB 8'h14
`define TMS_ADDR_RD2 8'h18
`define TMS_ADDR_LIM1 8'h20
`define TMS_ADDR_LIMA 8'h24
`define TMS_ADDR_LIM2 8'h28
`define TMS_ADDR_STAT 8'h30
`define TMS_ADDR_FAN 8'h38
`define TMS_ADDR_CTRL 8'h40

// Field positions.
`define TMS_AVG_MSB 7
`define TMS_AVG_LSB 5
`define TMS_START_BIT 0
`define TMS_LOCK_BIT 1
`define TMS_RUN_BIT 2
`define TMS_FAN_AUTO_BIT 16

// Reset values.
`define TMS_AVG_RST 3'h2
`define TMS_LIM_RST 16'hFF00
`define TMS_FAN_RST 17'h0_FF80

// Channel codes, in sampling order.
`define TMS_CH_RD1 2'h0
`define TMS_CH_AMB 2'h1
`define TMS_CH_RD2 2'h2

// AXI responses.
`define TMS_RESP_OKAY 2'h0
`define TMS_RESP_SLVERR 2'h2

// Timing: clock rate, nominal pass times and conversions per pass.
`define TMS_CLK_MHZ 100
`define TMS_PASS_US_A0 587400
`define TMS_PASS_US_A1 73400
`define TMS_PASS_US_A2 150800
`define TMS_PASS_US_A3 301500
`define TMS_CONV_A0 264
`define TMS_CONV_A1 33
`define TMS_CONV_A2 48
`define TMS_CONV_A3 96

`endif

// ===== rtl/tms_avg_decode.v
`timescale 1ns/100ps
`include "tms_defs.vh"

// Turns the averaging field into the power of two of the average count for
// one channel, plus a code naming which pass timing applies.
module tms_avg_decode (
   input wire [2:0] avg_sel, // average_count_select field
   input wire is_ambient, // channel is the ambient sensor
   output reg [2:0] avg_log2, // log2 of averages for this channel
   output reg [1:0] timing_sel // pass timing class
);

   always @* begin
      if (avg_sel[2]) begin
         avg_log2 = 3'h5;
         timing_sel = 2'h3;
      end else if (avg_sel[1]) begin
         avg_log2 = 3'h4;
         timing_sel = 2'h2;
      end else if (avg_sel[0]) begin
         avg_log2 = is_ambient ? 3'h0 : 3'h4;
         timing_sel = 2'h1;
      end else begin
         avg_log2 = is_ambient ? 3'h3 : 3'h7;
         timing_sel = 2'h0;
      end
   end

endmodule

// ===== rtl/tms_sequencer.v
// Function
// - Bits 7:5 of the config register choose averages per measurement.
// - Field top bit set gives 32 averages on every channel.
// - 000 gives 128 diode/8 ambient; 001 gives 16/1; 01x gives 16 all.
// - Averaging field resets to 010, sixteen averages everywhere.
// - Monitoring starts only after software writes one to start bit.
// - Running passes repeat back to back with no idle gap.
// - Order is remote diode one, ambient, remote diode two, then wrap.
// - Default setting makes one full pass take nominally 150.8 ms.
// - Pass time is 587.4, 73.4, 150.8 or 301.5 ms by setting.
// - Each result is checked against limits; violations set status bits.
// - With auto fan selected, fan duty follows each new result.
// - Reading registers hold latest averages and are always readable.
// - Start bit zero keeps converter and sequence halted; registers work.
// - Start bit writes are ignored while the lock bit is set.
`timescale 1ns/100ps
`include "tms_defs.vh"

module tms_sequencer #(
   parameter integer SLOT_A0 =
      `TMS_PASS_US_A0 * `TMS_CLK_MHZ / `TMS_CONV_A0,
   parameter integer SLOT_A1 =
      `TMS_PASS_US_A1 * `TMS_CLK_MHZ / `TMS_CONV_A1,
   parameter integer SLOT_A2 =
      `TMS_PASS_US_A2 * `TMS_CLK_MHZ / `TMS_CONV_A2,
   parameter integer SLOT_A3 =
      `TMS_PASS_US_A3 * `TMS_CLK_MHZ / `TMS_CONV_A3
) (
   input wire aclk, // system clock
   input wire aresetn, // synchronous reset, active low
   input wire [7:0] s_axi_awaddr, // write address
   input wire [2:0] s_axi_awprot, // write protection, unused
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output wire [1:0] s_axi_bresp, // write response
   output wire s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire [2:0] s_axi_arprot, // read protection, unused
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output wire [31:0] s_axi_rdata, // read data
   output wire [1:0] s_axi_rresp, // read response
   output wire s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   output wire adc_enable, // converter powered and running
   output wire conv_start, // one-cycle conversion request
   output wire [1:0] conv_channel, // channel being converted
   input wire conv_valid, // one-cycle result strobe
   input wire [7:0] conv_data, // conversion result
   output wire [7:0] fan_duty // fan duty cycle
);

   localparam [19:0] SLOT0 = SLOT_A0[19:0];
   localparam [19:0] SLOT1 = SLOT_A1[19:0];
   localparam [19:0] SLOT2 = SLOT_A2[19:0];
   localparam [19:0] SLOT3 = SLOT_A3[19:0];

   localparam [4:0] S_OFF = 5'h01;
   localparam [4:0] S_LOAD = 5'h02;
   localparam [4:0] S_REQ = 5'h04;
   localparam [4:0] S_WAIT = 5'h08;
   localparam [4:0] S_UPD = 5'h10;

   reg awready_reg;
   reg wready_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg arready_reg;
   reg rvalid_reg;
   reg [1:0] rresp_reg;
   reg [31:0] rdata_reg;
   reg [7:0] waddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;

   reg [2:0] avg_sel_reg;
   reg start_reg;
   reg lock_reg;
   reg [15:0] lim_rd1_reg;
   reg [15:0] lim_amb_reg;
   reg [15:0] lim_rd2_reg;
   reg [16:0] fan_cfg_reg;
   reg [2:0] status_reg;
   reg [2:0] status_next;
   reg [7:0] rd1_reg;
   reg [7:0] amb_reg;
   reg [7:0] rd2_reg;

   reg [4:0] state_reg;
   reg [1:0] chan_reg;
   reg [2:0] log2_reg;
   reg [19:0] slot_reg;
   reg [19:0] timer_reg;
   reg [7:0] count_reg;
   reg [14:0] acc_reg;
   reg got_reg;
   reg conv_start_reg;
   reg adc_enable_reg;
   reg [2:0] hot_reg;
   reg [7:0] fan_duty_reg;
   reg [2:0] viol_reg;

   wire [2:0] dec_log2;
   wire [1:0] dec_timing;
   wire wr_en;
   wire [31:0] wmask;
   wire [31:0] wval;
   wire [14:0] avg_full;
   wire [7:0] avg_val;
   wire [7:0] last_count;
   reg [15:0] cur_lim;
   reg [19:0] slot_sel;
   reg wr_hit;

   // The decode uses the live field; it is only sampled in S_LOAD.
   tms_avg_decode u_dec (
      .avg_sel(avg_sel_reg),
      .is_ambient(chan_reg == `TMS_CH_AMB),
      .avg_log2(dec_log2),
      .timing_sel(dec_timing)
   );

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign adc_enable = adc_enable_reg;
   assign conv_start = conv_start_reg;
   assign conv_channel = chan_reg;
   assign fan_duty = fan_duty_reg;

   // Both halves of a write are held; the write happens once both are in.
   assign wr_en = !awready_reg && !wready_reg && !bvalid_reg;
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                   {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign wval = wdata_reg & wmask;

   assign avg_full = acc_reg >> log2_reg;
   assign avg_val = avg_full[7:0];
   assign last_count = (8'h01 << log2_reg) - 8'h01;

   always @* begin
      case (dec_timing)
         2'h0: slot_sel = SLOT0;
         2'h1: slot_sel = SLOT1;
         2'h2: slot_sel = SLOT2;
         default: slot_sel = SLOT3;
      endcase
   end

   always @* begin
      case (chan_reg)
         `TMS_CH_RD1: cur_lim = lim_rd1_reg;
         `TMS_CH_AMB: cur_lim = lim_amb_reg;
         default: cur_lim = lim_rd2_reg;
      endcase
   end

   always @* begin
      case (waddr_reg)
         `TMS_ADDR_CFG, `TMS_ADDR_CTRL, `TMS_ADDR_LIM1, `TMS_ADDR_LIMA,
         `TMS_ADDR_LIM2, `TMS_ADDR_STAT, `TMS_ADDR_FAN,
         `TMS_ADDR_RD1, `TMS_ADDR_AMB, `TMS_ADDR_RD2: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // AXI write channel handshakes.
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= `TMS_RESP_OKAY;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            waddr_reg <= s_axi_awaddr;
            awready_reg <= 1'b0;
         end
         if (s_axi_wvalid && wready_reg) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            wready_reg <= 1'b0;
         end
         if (wr_en) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `TMS_RESP_OKAY : `TMS_RESP_SLVERR;
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // Software-written registers. Reading registers ignore writes.
   always @(posedge aclk) begin
      if (!aresetn) begin
         avg_sel_reg <= `TMS_AVG_RST;
         start_reg <= 1'b0;
         lock_reg <= 1'b0;
         lim_rd1_reg <= `TMS_LIM_RST;
         lim_amb_reg <= `TMS_LIM_RST;
         lim_rd2_reg <= `TMS_LIM_RST;
         fan_cfg_reg <= `TMS_FAN_RST;
      end else if (wr_en) begin
         case (waddr_reg)
            `TMS_ADDR_CFG: begin
               if (wstrb_reg[0]) begin
                  avg_sel_reg <= wdata_reg[`TMS_AVG_MSB:`TMS_AVG_LSB];
               end
            end
            `TMS_ADDR_CTRL: begin
               if (wstrb_reg[0] && !lock_reg) begin
                  start_reg <= wdata_reg[`TMS_START_BIT];
               end
               // Lock only sets; it holds until reset so it cannot be undone.
               if (wstrb_reg[0] && wdata_reg[`TMS_LOCK_BIT]) begin
                  lock_reg <= 1'b1;
               end
            end
            `TMS_ADDR_LIM1: lim_rd1_reg <= (lim_rd1_reg & ~wmask[15:0]) |
                                           wval[15:0];
            `TMS_ADDR_LIMA: lim_amb_reg <= (lim_amb_reg & ~wmask[15:0]) |
                                           wval[15:0];
            `TMS_ADDR_LIM2: lim_rd2_reg <= (lim_rd2_reg & ~wmask[15:0]) |
                                           wval[15:0];
            `TMS_ADDR_FAN: fan_cfg_reg <= (fan_cfg_reg & ~wmask[16:0]) |
                                          wval[16:0];
            default: begin
            end
         endcase
      end
   end

   // Status bits: a new violation wins over a write-one-to-clear.
   always @* begin
      status_next = status_reg;
      if (wr_en && waddr_reg == `TMS_ADDR_STAT && wstrb_reg[0]) begin
         status_next = status_next & ~wdata_reg[2:0];
      end
      status_next = status_next | viol_reg;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= 3'h0;
      end else begin
         status_reg <= status_next;
      end
   end

   // AXI read channel; every register reads at any time.
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= `TMS_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= `TMS_RESP_OKAY;
         case (s_axi_araddr)
            `TMS_ADDR_CFG: rdata_reg <= {24'h00_0000, avg_sel_reg, 5'h00};
            `TMS_ADDR_CTRL: rdata_reg <= {29'h0000_0000, !state_reg[0],
                                          lock_reg, start_reg};
            `TMS_ADDR_RD1: rdata_reg <= {24'h00_0000, rd1_reg};
            `TMS_ADDR_AMB: rdata_reg <= {24'h00_0000, amb_reg};
            `TMS_ADDR_RD2: rdata_reg <= {24'h00_0000, rd2_reg};
            `TMS_ADDR_LIM1: rdata_reg <= {16'h0000, lim_rd1_reg};
            `TMS_ADDR_LIMA: rdata_reg <= {16'h0000, lim_amb_reg};
            `TMS_ADDR_LIM2: rdata_reg <= {16'h0000, lim_rd2_reg};
            `TMS_ADDR_STAT: rdata_reg <= {29'h0000_0000, status_reg};
            `TMS_ADDR_FAN: rdata_reg <= {15'h0000, fan_cfg_reg};
            default: begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= `TMS_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // Conversion sequencer. Each conversion owns a fixed time slot so that a
   // pass takes the nominal time; a slow converter stretches the slot.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= S_OFF;
         chan_reg <= `TMS_CH_RD1;
         log2_reg <= 3'h0;
         slot_reg <= 20'h0_0000;
         timer_reg <= 20'h0_0000;
         count_reg <= 8'h00;
         acc_reg <= 15'h0000;
         got_reg <= 1'b0;
         conv_start_reg <= 1'b0;
         adc_enable_reg <= 1'b0;
         rd1_reg <= 8'h00;
         rd2_reg <= 8'h00;
         amb_reg <= 8'h00;
         viol_reg <= 3'h0;
         hot_reg <= 3'h0;
      end else begin
         conv_start_reg <= 1'b0;
         viol_reg <= 3'h0;
         if (!start_reg) begin
            // Clearing start abandons the channel in flight.
            state_reg <= S_OFF;
            adc_enable_reg <= 1'b0;
            chan_reg <= `TMS_CH_RD1;
         end else begin
            case (state_reg)
               S_OFF: begin
                  adc_enable_reg <= 1'b1;
                  state_reg <= S_LOAD;
               end
               S_LOAD: begin
                  // Setting is frozen for the whole channel.
                  log2_reg <= dec_log2;
                  slot_reg <= slot_sel;
                  count_reg <= 8'h00;
                  acc_reg <= 15'h0000;
                  state_reg <= S_REQ;
               end
               S_REQ: begin
                  conv_start_reg <= 1'b1;
                  timer_reg <= slot_reg - 20'h0_0001;
                  got_reg <= 1'b0;
                  state_reg <= S_WAIT;
               end
               S_WAIT: begin
                  if (timer_reg != 20'h0_0000) begin
                     timer_reg <= timer_reg - 20'h0_0001;
                  end
                  if (conv_valid && !got_reg) begin
                     acc_reg <= acc_reg + {7'h00, conv_data};
                     got_reg <= 1'b1;
                  end
                  if (got_reg && timer_reg == 20'h0_0000) begin
                     if (count_reg == last_count) begin
                        state_reg <= S_UPD;
                     end else begin
                        count_reg <= count_reg + 8'h01;
                        state_reg <= S_REQ;
                     end
                  end
               end
               S_UPD: begin
                  case (chan_reg)
                     `TMS_CH_RD1: rd1_reg <= avg_val;
                     `TMS_CH_AMB: amb_reg <= avg_val;
                     default: rd2_reg <= avg_val;
                  endcase
                  if (avg_val > cur_lim[15:8] || avg_val < cur_lim[7:0]) begin
                     viol_reg[chan_reg] <= 1'b1;
                  end
                  hot_reg[chan_reg] <= avg_val >= fan_cfg_reg[15:8];
                  if (chan_reg == `TMS_CH_RD2) begin
                     chan_reg <= `TMS_CH_RD1;
                  end else begin
                     chan_reg <= chan_reg + 2'h1;
                  end
                  state_reg <= S_LOAD;
               end
               default: state_reg <= S_OFF;
            endcase
         end
      end
   end

   // Fan duty: full when any channel is at or over the threshold.
   always @(posedge aclk) begin
      if (!aresetn) begin
         fan_duty_reg <= 8'h00;
      end else if (fan_cfg_reg[`TMS_FAN_AUTO_BIT] && hot_reg != 3'h0) begin
         fan_duty_reg <= 8'hFF;
      end else begin
         fan_duty_reg <= fan_cfg_reg[7:0];
      end
   end

endmodule

// ===== testbench/tms_sva.sv
`timescale 1ns/100ps
module tms_sva #(
   parameter integer SLOT_A0 = 20, // slot, averaging 000
   parameter integer SLOT_A1 = 20, // slot, averaging 001
   parameter integer SLOT_A2 = 30, // slot, averaging 01x
   parameter integer SLOT_A3 = 30 // slot, averaging 1xx
) (
   input wire aclk, // clock
   input wire aresetn, // reset, active low
   input wire s_axi_awvalid, // write address valid
   input wire s_axi_awready, // write address ready
   input wire s_axi_wvalid, // write data valid
   input wire s_axi_wready, // write data ready
   input wire s_axi_bvalid, // write response valid
   input wire s_axi_arvalid, // read address valid
   input wire s_axi_arready, // read address ready
   input wire s_axi_rvalid, // read data valid
   input wire adc_enable, // converter awake
   input wire conv_start, // conversion request
   input wire [1:0] conv_channel // channel converted
);
   // Loose bound on the gap between requests of a running converter.
   localparam int GAP_HI = SLOT_A0 + SLOT_A1 + SLOT_A2 + SLOT_A3;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_quiet;
      !conv_start [*8];
   endsequence
   AST_ASLEEP_NO_CONV: assert property (!adc_enable |-> !conv_start)
      else $error("conversion request while asleep");
   AST_ASLEEP_CHAN: assert property (
      !adc_enable && !$past(adc_enable) |-> conv_channel == 2'h0)
      else $error("channel not parked while asleep");
   AST_SLOT_MIN: assert property (conv_start |=> s_quiet)
      else $error("conversion requests too close");
   AST_NO_IDLE: assert property (
      conv_start |-> ##[1:GAP_HI] (conv_start || !adc_enable))
      else $error("idle pause in running sequence");
   AST_CHAN_STABLE: assert property (
      conv_start |=> ($stable(conv_channel) || !adc_enable) [*8])
      else $error("channel moved during conversion");
   AST_CHAN_ORDER: assert property (
      adc_enable && $past(adc_enable) && conv_channel != $past(conv_channel)
      |-> conv_channel == (($past(conv_channel) == 2'h2) ? 2'h0 :
      $past(conv_channel) + 2'h1))
      else $error("channel order broken");
   AST_WRITE_RESP: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_READ_RESP: assert property (
      s_rd_taken |=> s_axi_rvalid ##0 !s_axi_arready)
      else $error("read response late");
endmodule

bind tms_sequencer tms_sva #(.SLOT_A0(SLOT_A0), .SLOT_A1(SLOT_A1),
   .SLOT_A2(SLOT_A2), .SLOT_A3(SLOT_A3)) i_sva (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .adc_enable, .conv_start, .conv_channel);

// ===== testbench/tms_adc_model.sv
`timescale 1ns/100ps
module tms_adc_model (
   input wire aclk, // clock
   input wire aresetn, // reset, active low
   input wire conv_start, // conversion request
   input wire [1:0] conv_channel, // channel to convert
   input wire [7:0] delay, // cycles to answer, at least one
   input wire [23:0] vals, // result per channel
   output logic conv_valid, // result strobe
   output logic [7:0] conv_data // result
);
   logic [7:0] cnt_reg;
   logic [1:0] ch_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= 8'h00;
         ch_reg <= 2'h0;
         conv_valid <= 1'h0;
         conv_data <= 8'h5a;
      end else begin
         conv_valid <= 1'h0;
         // Outside the strobe the data lines toggle, so stale values fail.
         conv_data <= ~conv_data;
         if (conv_start) begin
            cnt_reg <= delay;
            ch_reg <= conv_channel;
         end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
               conv_valid <= 1'h1;
               conv_data <= vals[ch_reg * 8 +: 8];
            end
         end
      end
   end
endmodule

// ===== testbench/temperature_monitor_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "tms_defs.vh"
module temperature_monitor_sequencer_tb_top;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic aclk;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic [7:0] delay = 8'h01;
   logic [23:0] vals = 24'h60_4021;
   logic [3:0] wstrb = 4'hf;
   logic [2:0] prot = 3'h0;
   wire awready, wready, bvalid, arready, rvalid;
   wire adc_enable, conv_start, conv_valid;
   wire [1:0] bresp, rresp, conv_channel;
   wire [31:0] rdata;
   wire [7:0] conv_data, fan_duty;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int seg_n = 0;
   int seg_gap = 0;
   int last_t = 0;
   logic [1:0] seg_ch = 2'h0;
   int q_ch[$];
   int q_n[$];
   int q_gap[$];
   logic [31:0] rd_val;
   logic [1:0] rd_resp;

   tms_sequencer #(.SLOT_A0(20), .SLOT_A1(20), .SLOT_A2(30), .SLOT_A3(30))
   i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .adc_enable(adc_enable), .conv_start(conv_start),
      .conv_channel(conv_channel), .conv_valid(conv_valid),
      .conv_data(conv_data), .fan_duty(fan_duty));

   tms_adc_model i_adc (.aclk(aclk), .aresetn(aresetn),
      .conv_start(conv_start), .conv_channel(conv_channel), .delay(delay),
      .vals(vals), .conv_valid(conv_valid), .conv_data(conv_data));

   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   task end_of_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Groups conversion requests into runs per channel, with their spacing.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         $display("ERROR timeout expected done seen cycle %0d", cyc);
         end_of_test();
      end else if (!aresetn)
         seg_n = 0;
      else if (conv_start) begin
         if (seg_n != 0 && conv_channel !== seg_ch) begin
            q_ch.push_back(seg_ch);
            q_n.push_back(seg_n);
            q_gap.push_back(seg_gap);
            seg_n = 0;
            seg_gap = 0;
         end
         if (seg_n != 0)
            seg_gap = cyc - last_t;
         last_t = cyc;
         seg_ch = conv_channel;
         seg_n++;
      end
   end

   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      rd_resp = bresp;
      bready <= 1'h0;
      @(posedge aclk);
      chk("bresp", {30'h0, er}, {30'h0, rd_resp});
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
      input logic [31:0] m);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rd_val = rdata;
      rd_resp = rresp;
      rready <= 1'h0;
      @(posedge aclk);
      chk("rdata", e, rd_val & m);
      chk("rresp", {30'h0, er}, {30'h0, rd_resp});
   endtask

   task seg(input int ch, input int n, input int gap);
      // A segment that never closes is caught by the cycle ceiling.
      while (q_n.size() == 0)
         @(posedge aclk);
      chk("seg_ch", ch, q_ch.pop_front());
      chk("seg_n", n, q_n.pop_front());
      chk("seg_gap", gap, q_gap.pop_front());
   endtask

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(`TMS_ADDR_CFG, 32'h0000_0040, `TMS_RESP_OKAY, ALL);
      rd(`TMS_ADDR_LIMA, 32'h0000_ff00, `TMS_RESP_OKAY, ALL);
      rd(`TMS_ADDR_FAN, 32'h0000_ff80, `TMS_RESP_OKAY, ALL);
      rd(8'h0c, 32'h0000_0000, `TMS_RESP_SLVERR, ALL);
      wr(8'h0c, 32'h0000_0001, `TMS_RESP_SLVERR);
      // Only byte lane one may land; protection bits must not matter.
      wstrb <= 4'h2;
      prot <= 3'h7;
      wr(`TMS_ADDR_LIM1, 32'h0000_4455, `TMS_RESP_OKAY);
      wstrb <= 4'hf;
      rd(`TMS_ADDR_LIM1, 32'h0000_4400, `TMS_RESP_OKAY, ALL);
      prot <= 3'h0;
      repeat (50) @(posedge aclk);
      chk("starts_asleep", 32'h0, seg_n);
      chk("adc_enable", 32'h0, {31'h0, adc_enable});
      wr(`TMS_ADDR_CFG, 32'h0000_0020, `TMS_RESP_OKAY);
      wr(`TMS_ADDR_LIMA, 32'h0000_3000, `TMS_RESP_OKAY);
      wr(`TMS_ADDR_FAN, 32'h0001_5033, `TMS_RESP_OKAY);
      wr(`TMS_ADDR_CTRL, 32'h0000_0001, `TMS_RESP_OKAY);
      seg(0, 16, 21);
      wr(`TMS_ADDR_CFG, 32'h0000_0080, `TMS_RESP_OKAY);
      seg(1, 1, 0);
      seg(2, 32, 31);
      delay <= 8'h0f;
      seg(0, 32, 31);
      seg(1, 32, 31);
      wr(`TMS_ADDR_CFG, 32'h0000_0000, `TMS_RESP_OKAY);
      seg(2, 32, 31);
      seg(0, 128, 21);
      seg(1, 8, 21);
      wr(`TMS_ADDR_CFG, 32'h0000_0060, `TMS_RESP_OKAY);
      seg(2, 128, 21);
      seg(0, 16, 31);
      seg(1, 16, 31);
      rd(`TMS_ADDR_RD1, 32'h0000_0021, `TMS_RESP_OKAY, ALL);
      rd(`TMS_ADDR_AMB, 32'h0000_0040, `TMS_RESP_OKAY, ALL);
      rd(`TMS_ADDR_RD2, 32'h0000_0060, `TMS_RESP_OKAY, ALL);
      rd(`TMS_ADDR_STAT, 32'h0000_0002, `TMS_RESP_OKAY, 32'h0000_0007);
      chk("fan_duty", 32'hff, {24'h0, fan_duty});
      wr(`TMS_ADDR_FAN, 32'h0001_ff33, `TMS_RESP_OKAY);
      seg(2, 16, 31);
      chk("fan_duty", 32'h33, {24'h0, fan_duty});
      wr(`TMS_ADDR_CTRL, 32'h0000_0000, `TMS_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("adc_enable", 32'h0, {31'h0, adc_enable});
      rd(`TMS_ADDR_AMB, 32'h0000_0040, `TMS_RESP_OKAY, ALL);
      rd(`TMS_ADDR_CTRL, 32'h0000_0000, `TMS_RESP_OKAY, 32'h0000_0007);
      wr(`TMS_ADDR_CTRL, 32'h0000_0003, `TMS_RESP_OKAY);
      wr(`TMS_ADDR_CTRL, 32'h0000_0000, `TMS_RESP_OKAY);
      rd(`TMS_ADDR_CTRL, 32'h0000_0003, `TMS_RESP_OKAY, 32'h0000_0003);
      chk("adc_enable", 32'h1, {31'h0, adc_enable});
      end_of_test();
   end
endmodule
